// [design/enc_cnt_pkg.sv]
`default_nettype none
package enc_cnt_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned MAX_PULSE_HZ  = 80_000;    // pulse/dir and up/down
    localparam int unsigned MAX_QUAD_HZ   = 160_000;   // quadrature transitions
    localparam int unsigned WIN_LONG_MS   = 1000;
    localparam int unsigned WIN_SHORT_MS  = 200;
    localparam int unsigned WIN_LONG_CYC  = (CLK_HZ / 1000) * WIN_LONG_MS;
    localparam int unsigned WIN_SHORT_CYC = (CLK_HZ / 1000) * WIN_SHORT_MS;
    localparam int unsigned WIN_W         = 24;        // window counter width

    // register addresses (word index on the plain port)
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_PRESET = 4'h1;
    localparam logic [3:0] A_CMD    = 4'h2;
    localparam logic [3:0] A_COUNT  = 4'h3;
    localparam logic [3:0] A_FREQ   = 4'h4;
    localparam logic [3:0] A_LO0    = 4'h5;
    localparam logic [3:0] A_HI0    = 4'h6;
    localparam logic [3:0] A_LO1    = 4'h7;
    localparam logic [3:0] A_HI1    = 4'h8;

    // control field positions
    localparam int unsigned MODE_LSB = 0;   // two bits
    localparam int unsigned WSEL_BIT = 2;   // 1 selects the short window
    localparam int unsigned TRIG_LSB = 4;   // two bits
    localparam int unsigned CMD_BIT  = 0;   // preset command

    // counting modes
    localparam logic [1:0] MODE_PD   = 2'h0;
    localparam logic [1:0] MODE_UD   = 2'h1;
    localparam logic [1:0] MODE_QUAD = 2'h2;
    localparam logic [1:0] MODE_BAD  = 2'h3;

    // preset trigger sources
    localparam logic [1:0] TRIG_IDX  = 2'h0;
    localparam logic [1:0] TRIG_LS   = 2'h1;
    localparam logic [1:0] TRIG_BOTH = 2'h2;
    localparam logic [1:0] TRIG_SW   = 2'h3;

    // reset values
    localparam logic [31:0] RST_LO   = 32'h0000_0001;  // lo above hi: empty range
    localparam logic [31:0] RST_HI   = 32'h0000_0000;
    localparam logic [31:0] ONE      = 32'h0000_0001;
    localparam logic [15:0] FREQ_MAX = 16'h7fff;
    localparam logic [15:0] FREQ_MIN = 16'h8000;

    // register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // whole state of the counter
    typedef struct packed {
        logic            a_p;
        logic            b_p;
        logic [1:0]      mode;
        logic [1:0]      trig;
        logic            wsel;
        logic [31:0]     preset;
        logic [31:0]     lo0;
        logic [31:0]     hi0;
        logic [31:0]     lo1;
        logic [31:0]     hi1;
        logic [31:0]     count;
        logic [31:0]     acc;
        logic [15:0]     freq;
        logic [WIN_W-1:0] win;
        logic            out0;
        logic            out1;
        logic [31:0]     rdata;
    } st_t;
endpackage
`default_nettype wire

// [design/encoder_pulse_counter.sv]
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module encoder_pulse_counter #(
    parameter int unsigned WIN_LONG_CYC  = enc_cnt_pkg::WIN_LONG_CYC,
    parameter int unsigned WIN_SHORT_CYC = enc_cnt_pkg::WIN_SHORT_CYC
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // register port
    input  wire enc_cnt_pkg::bus_req_t bus_i,
    output logic [31:0]                rdata,
    // encoder and preset inputs
    input  wire logic                  a_in,
    input  wire logic                  b_in,
    input  wire logic                  index_in,
    input  wire logic                  limit_switch_input,
    // range outputs
    output logic                       out0,
    output logic                       out1
);
    import enc_cnt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks; a bad parameter stops the build, not the run
    if (WIN_LONG_CYC < 2 || WIN_SHORT_CYC < 2 ||
        WIN_LONG_CYC > (1 << WIN_W) || WIN_SHORT_CYC > (1 << WIN_W)) begin : win_check
        $error("window length out of range");
    end
    // quadrature needs every transition seen as its own sample
    if (CLK_HZ < 2 * MAX_QUAD_HZ) begin : clk_check
        $error("clock too slow for input rate");
    end

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic [1:0] rs_q;           // reset synchroniser
    logic       rst_n;          // released reset

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rs_q <= 2'h0;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // inclusive signed range test
    function automatic logic in_range(input logic [31:0] c,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = ($signed(c) >= $signed(lo)) && ($signed(c) <= $signed(hi));
    endfunction

    // clamp the window sum into a 16-bit signed value
    function automatic logic [15:0] sat16(input logic [31:0] v);
        if ($signed(v) > $signed(32'h0000_7fff)) begin
            sat16 = FREQ_MAX;
        end else if ($signed(v) < $signed(32'hffff_8000)) begin
            sat16 = FREQ_MIN;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state and decoded events
    st_t              q;            // registered state
    st_t              d;            // next state
    logic             up;           // count one up this cycle
    logic             dn;           // count one down this cycle
    logic             quad_bad;     // both phases moved together
    logic             hw_hit;       // hardware preset condition
    logic             cmd_pre;      // preset command written
    logic             preset_now;   // preset taken this cycle
    logic             win_end;      // last cycle of a window
    logic [WIN_W-1:0] win_last;     // terminal window count
    logic [31:0]      acc_n;        // window sum incl. this cycle
    logic [31:0]      rd_val;       // read mux

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        d        = q;
        up       = 1'b0;
        dn       = 1'b0;
        quad_bad = 1'b0;
        hw_hit   = 1'b0;
        rd_val   = 32'h0000_0000;
        d.a_p    = a_in;
        d.b_p    = b_in;

        // edge decoding per mode; only the chosen mode acts
        unique case (q.mode)
            MODE_PD: begin
                // rising edge on A, B level picks direction
                up = a_in && !q.a_p && b_in;
                dn = a_in && !q.a_p && !b_in;
            end
            MODE_UD: begin
                // simultaneous edges on A and B cancel out
                up = a_in && !q.a_p && !(b_in && !q.b_p);
                dn = b_in && !q.b_p && !(a_in && !q.a_p);
            end
            MODE_QUAD: begin
                quad_bad = (a_in != q.a_p) && (b_in != q.b_p);
                if (!quad_bad && ((a_in != q.a_p) || (b_in != q.b_p))) begin
                    // a_new xor b_old is high when A leads
                    up = a_in ^ q.b_p;
                    dn = !(a_in ^ q.b_p);
                end
            end
            default: begin
                // illegal code never stored; counting halts
                up = 1'b0;
            end
        endcase

        // preset sources
        unique case (q.trig)
            TRIG_IDX:  hw_hit = index_in;
            TRIG_LS:   hw_hit = limit_switch_input;
            TRIG_BOTH: hw_hit = index_in && limit_switch_input;
            TRIG_SW:   hw_hit = 1'b0;
        endcase
        cmd_pre    = bus_i.wr && (bus_i.addr == A_CMD) && bus_i.wdata[CMD_BIT];
        preset_now = hw_hit || cmd_pre;

        // count: preset wins over motion, wraps naturally
        if (preset_now) begin
            d.count = q.preset;
        end else if (up) begin
            d.count = 32'(q.count + ONE);
        end else if (dn) begin
            d.count = 32'(q.count - ONE);
        end

        // window sum tracks motion even across presets
        acc_n = q.acc;
        if (up) begin
            acc_n = 32'(q.acc + ONE);
        end else if (dn) begin
            acc_n = 32'(q.acc - ONE);
        end
        win_last = q.wsel ? WIN_W'(WIN_SHORT_CYC - 1) : WIN_W'(WIN_LONG_CYC - 1);
        // >= keeps a shortened window from running past its end
        win_end  = (q.win >= win_last);
        if (win_end) begin
            d.freq = sat16(acc_n);
            d.acc  = 32'h0000_0000;
            d.win  = '0;
        end else begin
            d.acc  = acc_n;
            d.win  = WIN_W'(q.win + 1'b1);
        end

        // register writes
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                A_CTRL: begin
                    // a bad mode code keeps the old mode
                    if (bus_i.wdata[MODE_LSB+:2] != MODE_BAD) begin
                        d.mode = bus_i.wdata[MODE_LSB+:2];
                    end
                    d.wsel = bus_i.wdata[WSEL_BIT];
                    d.trig = bus_i.wdata[TRIG_LSB+:2];
                    // restart the window so the next value is clean
                    d.win  = '0;
                    d.acc  = 32'h0000_0000;
                end
                A_PRESET: d.preset = bus_i.wdata;
                A_LO0:    d.lo0    = bus_i.wdata;
                A_HI0:    d.hi0    = bus_i.wdata;
                A_LO1:    d.lo1    = bus_i.wdata;
                A_HI1:    d.hi1    = bus_i.wdata;
                default:  d.rdata  = 32'h0000_0000;  // command and read-only
            endcase
        end

        // outputs follow the new count and new ranges together
        d.out0 = in_range(d.count, d.lo0, d.hi0);
        d.out1 = in_range(d.count, d.lo1, d.hi1);

        // read mux; unmapped reads return zero
        unique case (bus_i.addr)
            A_CTRL:   rd_val = {26'h0, q.trig, 1'b0, q.wsel, q.mode};
            A_PRESET: rd_val = q.preset;
            A_COUNT:  rd_val = q.count;
            A_FREQ:   rd_val = {{16{q.freq[15]}}, q.freq};
            A_LO0:    rd_val = q.lo0;
            A_HI0:    rd_val = q.hi0;
            A_LO1:    rd_val = q.lo1;
            A_HI1:    rd_val = q.hi1;
            default:  rd_val = 32'h0000_0000;
        endcase
        // data stands only in the cycle after the strobe
        d.rdata = bus_i.rd ? rd_val : 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.trig   <= TRIG_SW;
            q.lo0    <= RST_LO;
            q.hi0    <= RST_HI;
            q.lo1    <= RST_LO;
            q.hi1    <= RST_HI;
        end else begin
            q <= d;
        end
    end

    // every output straight from the state register
    assign rdata = q.rdata;
    assign out0  = q.out0;
    assign out1  = q.out1;

    ////////////////////////////////////////////////////////////////////////
    // checks
    mode_legal_a: assert property (
        @(posedge clk) disable iff (!rst_n) q.mode != MODE_BAD)
        else $error("illegal mode stored");

    pd_count_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.mode == MODE_PD && !preset_now && a_in && !q.a_p && !b_in)
        |=> q.count == 32'($past(q.count) - ONE))
        else $error("pulse/dir down count wrong");

    ud_count_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.mode == MODE_UD && !preset_now && a_in && !q.a_p && !(b_in && !q.b_p))
        |=> q.count == 32'($past(q.count) + ONE))
        else $error("up/down up count wrong");

    quad_lead_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.mode == MODE_QUAD && !preset_now && !q.a_p && !q.b_p && a_in && !b_in)
        |=> q.count == 32'($past(q.count) + ONE))
        else $error("quadrature A lead not counted up");

    quad_bad_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.mode == MODE_QUAD && !preset_now && a_in != q.a_p && b_in != q.b_p)
        |=> $stable(q.count))
        else $error("double transition changed count");

    preset_load_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        preset_now |=> q.count == $past(q.preset))
        else $error("preset not loaded");

    trig_sw_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (q.trig == TRIG_SW && !cmd_pre && q.mode == MODE_PD && !(a_in && !q.a_p))
        |=> $stable(q.count))
        else $error("count moved without cause");

    freq_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !win_end |=> $stable(q.freq))
        else $error("frequency changed mid window");

    win_restart_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (win_end && !bus_i.wr) |=> (q.acc == 32'h0000_0000 && q.win == '0))
        else $error("window did not restart");

    out_range_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        q.out0 == in_range(q.count, q.lo0, q.hi0) &&
        q.out1 == in_range(q.count, q.lo1, q.hi1))
        else $error("output disagrees with range");

    // bounds count as inside: a count sitting on either end keeps out0 on
    bound_on_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($signed(q.lo0) <= $signed(q.hi0) && (q.count == q.lo0 || q.count == q.hi0)) |-> q.out0)
        else $error("inclusive bound left output off");

    range_wr_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (bus_i.wr && bus_i.addr == A_HI1) |=> q.hi1 == $past(bus_i.wdata))
        else $error("range update lost");

    read_once_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !bus_i.rd |=> q.rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

    quad_cover_c: cover property (
        @(posedge clk) disable iff (!rst_n) q.mode == MODE_QUAD && up);
    preset_cover_c: cover property (
        @(posedge clk) disable iff (!rst_n) hw_hit ##1 q.out0);
    window_cover_c: cover property (
        @(posedge clk) disable iff (!rst_n) win_end && acc_n != 32'h0000_0000);
endmodule
`default_nettype wire

// [verification/pulse_source.sv]
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// encoder or pulse train at the counter's pins
module pulse_source (
    // clock
    input  wire logic clk,
    // encoder lines
    output logic      a_out,
    output logic      b_out
);
    import enc_cnt_pkg::*;
    int phase = 0; // quadrature position, 0..3 in gray order

    // both lines low from time zero, so no edge is seen after reset
    initial begin
        a_out = 1'b0;
        b_out = 1'b0;
    end

    // every level stands two cycles, far faster than the rated pulse rates
    task automatic drive(input logic a, input logic b);
        @(posedge clk);
        a_out <= a;
        b_out <= b;
        @(posedge clk);
    endtask

    // one count in the given mode, up or down
    task automatic step(input logic [1:0] mode, input bit up);
        case (mode)
            MODE_QUAD: begin
                phase = up ? (phase + 1) % 4 : (phase + 3) % 4;
                drive(phase inside {1, 2}, phase >= 2);
            end
            MODE_UD: begin
                drive(up, !up);
                drive(1'b0, 1'b0);
            end
            default: begin
                drive(1'b0, up);
                drive(1'b1, up);
                drive(1'b0, up);
            end
        endcase
    endtask

    // both phases flip in one sample; a decoder must not count it
    task automatic jump();
        phase = (phase + 2) % 4;
        drive(phase inside {1, 2}, phase >= 2);
    endtask

    // back to both lines low, used only around mode changes
    task automatic idle();
        phase = 0;
        drive(1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

// [verification/encoder_pulse_counter_preset_window_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
module encoder_pulse_counter_preset_window_tb_top;
    import enc_cnt_pkg::*;
    localparam int unsigned LONG_CYC  = 60; // short windows keep the run brief
    localparam int unsigned SHORT_CYC = 24;
    logic        clk = 1'b0;
    logic        nrst;
    bus_req_t    bus_q;
    logic [31:0] rdata;
    logic        index_q;
    logic        limit_q;
    wire logic   a;
    wire logic   b;
    logic        out0;
    logic        out1;
    logic [1:0]  mode;         // mode the model believes active
    logic [31:0] word;         // last read data
    int          errors = 0;
    int          comparisons = 0;
    int          seed = 32'h7adc_65e3;
    int          cnt = 0;      // model count, int wraps like the hardware
    int          pre = 0;      // model preset value
    int          cyc = 0;      // free cycle counter
    int          t0;
    int          lo[2];
    int          hi[2];

    // 10 MHz clock
    always #50 clk = ~clk;
    // free cycle count used to time the frequency windows
    always @(posedge clk) cyc <= cyc + 1;

    encoder_pulse_counter #(.WIN_LONG_CYC(LONG_CYC), .WIN_SHORT_CYC(SHORT_CYC)) i_encoder_pulse_counter (
        .clk(clk), .nrst(nrst), .bus_i(bus_q), .rdata(rdata), .a_in(a), .b_in(b),
        .index_in(index_q), .limit_switch_input(limit_q), .out0(out0), .out1(out1));
    pulse_source i_pulse_source (.clk(clk), .a_out(a), .b_out(b));

    //////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    // one write cycle, released after the taking edge
    task automatic bus_write(input logic [3:0] addr, input logic [31:0] data);
        @(posedge clk);
        bus_q.addr  <= addr;
        bus_q.wdata <= data;
        bus_q.wr    <= 1'b1;
        @(posedge clk);
        bus_q.wr    <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic bus_read(input logic [3:0] addr, output logic [31:0] data);
        @(posedge clk);
        bus_q.addr <= addr;
        bus_q.rd   <= 1'b1;
        @(posedge clk);
        bus_q.rd   <= 1'b0;
        #1;
        data = rdata;
    endtask

    function automatic logic in_range(input int i);
        return lo[i] <= cnt && cnt <= hi[i];
    endfunction

    task automatic check_state();
        bus_read(A_COUNT, word);
        check_word(word, 32'(cnt), "count");
        check_bit(out0, in_range(0), "out0");
        check_bit(out1, in_range(1), "out1");
    endtask

    task automatic set_ctrl(input logic [1:0] m, input logic wsel, input logic [1:0] trig);
        bus_write(A_CTRL, {26'h000_0000, trig, 1'b0, wsel, m});
        if (m != MODE_BAD)
            mode = m;
    endtask

    // one count; outputs are looked at just after the counting edge in quadrature mode, two cycles after it in the other modes
    task automatic step(input bit up);
        i_pulse_source.step(mode, up);
        cnt = up ? cnt + 1 : cnt - 1;
        #1;
        check_bit(out0, in_range(0), "out0 at count edge");
        check_bit(out1, in_range(1), "out1 at count edge");
        check_state();
    endtask

    task automatic preset_cmd(input logic [31:0] p);
        bus_write(A_PRESET, p);
        bus_write(A_CMD, 32'h0000_0001);
        pre = int'(p);
        cnt = pre;
        check_state();
    endtask

    task automatic set_range(input int i, input int l, input int h);
        bus_write(i ? A_LO1 : A_LO0, 32'(l));
        bus_write(i ? A_HI1 : A_HI0, 32'(h));
        lo[i] = l;
        hi[i] = h;
    endtask

    //////////////////////////////////////////////////////////////////////
    // a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run();
    end

    // reset, then every scenario in turn, then the verdict
    initial begin
        nrst = 1'b0;
        bus_q = '0;
        index_q = 1'b0;
        limit_q = 1'b0;
        lo = '{1, 1};
        hi = '{0, 0};
        mode = MODE_PD;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, unmapped read, idle read data
        check_state();
        bus_read(A_LO0, word);
        check_word(word, RST_LO, "lo0 reset");
        bus_read(4'h9, word);
        check_word(word, 32'h0000_0000, "unmapped");
        @(posedge clk);
        #1 check_word(rdata, 32'h0000_0000, "idle rdata");
        // every mode with random directions
        for (int m = 0; m < 3; m++) begin
            set_ctrl(2'(m), 1'b0, TRIG_SW);
            i_pulse_source.idle();
            preset_cmd(32'($random(seed)));
            repeat (12) step(1'($random(seed)));
        end
        i_pulse_source.jump();
        check_state();
        // refused mode code keeps quadrature
        set_ctrl(MODE_BAD, 1'b0, TRIG_SW);
        step(1'b1);
        preset_cmd(32'h7fff_ffff);
        step(1'b1);
        step(1'b0);
        // ranges straddling the count; range 0 entered and left both ways, range 1 left both ways
        preset_cmd(32'($random(seed) % 1000));
        set_range(0, cnt + 1, cnt + 2);
        set_range(1, cnt - 1, cnt);
        check_state();
        repeat (3) step(1'b1);
        repeat (5) step(1'b0);
        // every trigger source against every input combination
        for (int t = 0; t < 4; t++) begin
            set_ctrl(MODE_QUAD, 1'b0, 2'(t));
            for (int c = 0; c < 4; c++) begin
                step(1'b1);
                @(posedge clk);
                index_q <= c[0];
                limit_q <= c[1];
                repeat (3) @(posedge clk);
                index_q <= 1'b0;
                limit_q <= 1'b0;
                if ((t == 0 && c[0]) || (t == 1 && c[1]) || (t == 2 && c == 3))
                    cnt = pre;
                check_state();
            end
        end
        // long window: five counts up
        set_ctrl(MODE_QUAD, 1'b0, TRIG_SW);
        t0 = cyc;
        repeat (5) i_pulse_source.step(mode, 1'b1);
        while (cyc < t0 + LONG_CYC + 4) @(posedge clk);
        bus_read(A_FREQ, word);
        check_word(word, 32'h0000_0005, "freq long");
        // short window: three counts down, read sign extended
        set_ctrl(MODE_QUAD, 1'b1, TRIG_SW);
        t0 = cyc;
        repeat (3) i_pulse_source.step(mode, 1'b0);
        while (cyc < t0 + SHORT_CYC + 4) @(posedge clk);
        bus_read(A_FREQ, word);
        check_word(word, 32'hffff_fffd, "freq short");
        complete_run();
    end
endmodule
`default_nettype wire
